// File: rtl/dfc_pkg.sv
// constants and carrier types for the deframer and channel setup bank
//
// What this block does
// - link control bit 3: single or dual link
// - link control bit 2 pages link deframer
// - writing 09h holds paged deframer in reset
// - writing 01h releases paged deframer from reset
// - bit 7 at 453h enables descrambling
// - bits 4:0 at 453h: lanes minus one
// - bits 7:5 at 458h: subclass version
// - bits 4:0 at 458h: sample size minus one
// - channel page bits select channels written together
// - 12-bit gain split over 146h and 147h
// - gain code 800h means unity gain
// - bit 6 at 130h enables channel oscillator
// - bit 2 at 130h enables modulus accumulation
// - bit 1 at 130h selects delivered sideband
// - sideband zero upper, one lower inverted
package dfc_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int NUM_LINKS = 2;
   localparam int NUM_CHAN = 6;
   localparam int GAIN_W = 12;

   localparam logic [ADDR_W-1:0] OFS_CHAN_PAGE = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_OSC_CTRL = 12'h130;
   localparam logic [ADDR_W-1:0] OFS_GAIN_LO = 12'h146;
   localparam logic [ADDR_W-1:0] OFS_GAIN_HI = 12'h147;
   localparam logic [ADDR_W-1:0] OFS_LINK_CTRL = 12'h300;
   localparam logic [ADDR_W-1:0] OFS_SCR_LANES = 12'h453;
   localparam logic [ADDR_W-1:0] OFS_SUB_NP = 12'h458;
   localparam logic [ADDR_W-1:0] OFS_SOFT_RST = 12'h475;

   // link control fields
   localparam int LC_MODE_BIT = 3;
   localparam int LC_PAGE_BIT = 2;
   localparam int LC_EN_LSB = 0;
   localparam logic [DATA_W-1:0] LC_MASK = 8'h0F;
   // scramble and lane count fields
   localparam int SCR_BIT = 7;
   localparam int LANES_LSB = 0;
   localparam logic [DATA_W-1:0] SCR_MASK = 8'h9F;
   // subclass and sample size fields
   localparam int SUBCL_LSB = 5;
   localparam int NP_LSB = 0;
   // soft reset commands
   localparam logic [DATA_W-1:0] SRST_ENTER = 8'h09;
   localparam logic [DATA_W-1:0] SRST_LEAVE = 8'h01;
   // channel page, oscillator control, gain
   localparam logic [DATA_W-1:0] CHP_MASK = 8'h3F;
   localparam int OSC_EN_BIT = 6;
   localparam int OSC_MOD_BIT = 2;
   localparam int OSC_SB_BIT = 1;
   localparam int OSC_TONE_BIT = 0;
   localparam logic [DATA_W-1:0] OSC_MASK = 8'h47;
   localparam logic [DATA_W-1:0] GAIN_HI_MASK = 8'h0F;
   localparam logic [GAIN_W-1:0] GAIN_UNITY = 12'h800;
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

   typedef struct packed {
      logic soft_reset;
      logic descramble_en;
      logic [4:0] lanes_m1;
      logic [2:0] subclass;
      logic [4:0] sample_m1;
   } dfc_link_cfg_t;

   typedef struct packed {
      logic [GAIN_W-1:0] gain;
      logic osc_en;
      logic modulus_en;
      logic sideband_lower;
      logic test_tone;
   } dfc_chan_cfg_t;
endpackage : dfc_pkg

// File: rtl/dfc_setup_regs.sv
// register bank for link deframer setup and channel datapath controls
`timescale 1ns/100ps
module dfc_setup_regs (
   input wire logic clk,
   input wire logic rst,
   input wire logic [dfc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [dfc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [dfc_pkg::DATA_W-1:0] reg_rdata,
   input wire logic serial_link_config_dual,
   output logic link_dual,
   output logic link_page,
   output logic [1:0] link_enable,
   output logic mode_mismatch,
   output dfc_pkg::dfc_link_cfg_t [dfc_pkg::NUM_LINKS-1:0] link_cfg,
   output dfc_pkg::dfc_chan_cfg_t [dfc_pkg::NUM_CHAN-1:0] chan_cfg
);
   import dfc_pkg::*;

   logic [DATA_W-1:0] link_ctl_r;
   logic [DATA_W-1:0] chan_page_r;
   logic [DATA_W-1:0] rdata_r;
   logic mismatch_r;
   logic [DATA_W-1:0] scr_q [NUM_LINKS];
   logic [DATA_W-1:0] sub_q [NUM_LINKS];
   logic [DATA_W-1:0] srst_q [NUM_LINKS];
   logic [GAIN_W-1:0] gain_q [NUM_CHAN];
   logic [DATA_W-1:0] osc_q [NUM_CHAN];

   // address decode
   wire logic wr_link = reg_wr && (reg_addr == OFS_LINK_CTRL);
   wire logic wr_chp = reg_wr && (reg_addr == OFS_CHAN_PAGE);
   wire logic wr_scr = reg_wr && (reg_addr == OFS_SCR_LANES);
   wire logic wr_sub = reg_wr && (reg_addr == OFS_SUB_NP);
   wire logic wr_srst = reg_wr && (reg_addr == OFS_SOFT_RST);
   wire logic wr_glo = reg_wr && (reg_addr == OFS_GAIN_LO);
   wire logic wr_ghi = reg_wr && (reg_addr == OFS_GAIN_HI);
   wire logic wr_osc = reg_wr && (reg_addr == OFS_OSC_CTRL);

   wire logic page_now = link_ctl_r[LC_PAGE_BIT];

   // readback of channel registers comes from the lowest paged channel;
   // with several channels paged, the others can hold different values until a write through the page
   function automatic logic [2:0] first_sel(input logic [DATA_W-1:0] pg);
      logic [2:0] idx;
      idx = 3'h0;
      for (int k = NUM_CHAN - 1; k >= 0; k--) begin
         if (pg[k]) begin
            idx = 3'(k);
         end
      end
      return idx;
   endfunction : first_sel

   wire logic any_chan = |(chan_page_r & CHP_MASK);
   wire logic [2:0] rd_ch = first_sel(chan_page_r);
   wire logic [GAIN_W-1:0] rd_gain = any_chan ? gain_q[rd_ch] : GAIN_UNITY;
   wire logic [DATA_W-1:0] rd_glo = any_chan ? rd_gain[DATA_W-1:0] : BYTE_ZERO;
   wire logic [DATA_W-1:0] rd_ghi =
      any_chan ? DATA_W'(rd_gain[GAIN_W-1:DATA_W]) : BYTE_ZERO;
   wire logic [DATA_W-1:0] rd_osc = any_chan ? osc_q[rd_ch] : BYTE_ZERO;

   // unmapped addresses read as zero
   wire logic [DATA_W-1:0] rd_mux =
      (reg_addr == OFS_LINK_CTRL) ? link_ctl_r :
      (reg_addr == OFS_CHAN_PAGE) ? chan_page_r :
      (reg_addr == OFS_SCR_LANES) ? scr_q[page_now] :
      (reg_addr == OFS_SUB_NP) ? sub_q[page_now] :
      (reg_addr == OFS_SOFT_RST) ? srst_q[page_now] :
      (reg_addr == OFS_GAIN_LO) ? rd_glo :
      (reg_addr == OFS_GAIN_HI) ? rd_ghi :
      (reg_addr == OFS_OSC_CTRL) ? rd_osc : BYTE_ZERO;

   always_ff @(posedge clk) begin
      if (rst) begin
         link_ctl_r <= BYTE_ZERO;
         chan_page_r <= BYTE_ZERO;
         rdata_r <= BYTE_ZERO;
         mismatch_r <= 1'b0;
      end else begin
         if (wr_link) begin
            link_ctl_r <= reg_wdata & LC_MASK;
         end
         if (wr_chp) begin
            chan_page_r <= reg_wdata & CHP_MASK;
         end
         rdata_r <= reg_rd ? rd_mux : BYTE_ZERO;
         // flags a link mode that disagrees with the datapath mode
         mismatch_r <= link_ctl_r[LC_MODE_BIT] != serial_link_config_dual;
      end
   end

   assign reg_rdata = rdata_r;
   assign link_dual = link_ctl_r[LC_MODE_BIT];
   assign link_page = link_ctl_r[LC_PAGE_BIT];
   // software is expected to hold these at zero through setup
   assign link_enable = link_ctl_r[LC_EN_LSB+1:LC_EN_LSB];
   assign mode_mismatch = mismatch_r;

   for (genvar li = 0; li < NUM_LINKS; li++) begin : g_link
      wire logic sel = (page_now == 1'(li));
      logic [DATA_W-1:0] scr_r;
      logic [DATA_W-1:0] sub_r;
      logic [DATA_W-1:0] srst_byte_r;
      logic srst_r;
      always_ff @(posedge clk) begin
         if (rst) begin
            scr_r <= BYTE_ZERO;
            sub_r <= BYTE_ZERO;
            srst_byte_r <= BYTE_ZERO;
            srst_r <= 1'b0;
         end else begin
            if (wr_scr && sel) begin
               scr_r <= reg_wdata & SCR_MASK;
            end
            if (wr_sub && sel) begin
               sub_r <= reg_wdata;
            end
            if (wr_srst && sel) begin
               srst_byte_r <= reg_wdata;
               if (reg_wdata == SRST_ENTER) begin
                  srst_r <= 1'b1;
               end else if (reg_wdata == SRST_LEAVE) begin
                  srst_r <= 1'b0;
               end
            end
         end
      end
      assign scr_q[li] = scr_r;
      assign sub_q[li] = sub_r;
      assign srst_q[li] = srst_byte_r;
      assign link_cfg[li].soft_reset = srst_r;
      assign link_cfg[li].descramble_en = scr_r[SCR_BIT];
      assign link_cfg[li].lanes_m1 = scr_r[LANES_LSB+4:LANES_LSB];
      assign link_cfg[li].subclass = sub_r[SUBCL_LSB+2:SUBCL_LSB];
      assign link_cfg[li].sample_m1 = sub_r[NP_LSB+4:NP_LSB];
   end

   // one write lands in every paged channel at once, which is how
   // identical setups for several channels cost a single bus cycle
   for (genvar ci = 0; ci < NUM_CHAN; ci++) begin : g_chan
      wire logic sel = chan_page_r[ci];
      logic [GAIN_W-1:0] gain_r;
      logic [DATA_W-1:0] osc_r;
      always_ff @(posedge clk) begin
         if (rst) begin
            gain_r <= GAIN_UNITY;
            osc_r <= BYTE_ZERO;
         end else begin
            if (wr_glo && sel) begin
               gain_r[DATA_W-1:0] <= reg_wdata;
            end
            if (wr_ghi && sel) begin
               gain_r[GAIN_W-1:DATA_W] <= reg_wdata[GAIN_W-DATA_W-1:0];
            end
            if (wr_osc && sel) begin
               osc_r <= reg_wdata & OSC_MASK;
            end
         end
      end
      assign gain_q[ci] = gain_r;
      assign osc_q[ci] = osc_r;
      // linear code, unity at 800h
      assign chan_cfg[ci].gain = gain_r;
      assign chan_cfg[ci].osc_en = osc_r[OSC_EN_BIT];
      assign chan_cfg[ci].modulus_en = osc_r[OSC_MOD_BIT];
      // zero keeps the upper sideband, one the inverted lower
      assign chan_cfg[ci].sideband_lower = osc_r[OSC_SB_BIT];
      assign chan_cfg[ci].test_tone = osc_r[OSC_TONE_BIT];
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_mode_mismatch;
      ##1 (link_dual != serial_link_config_dual) |=> mode_mismatch;
   endproperty
   a_mode_mismatch: assert property (p_mode_mismatch)
      else $error("mode mismatch flag not raised");

   property p_link_mode;
      wr_link |=> link_dual == $past(reg_wdata[LC_MODE_BIT]);
   endproperty
   a_link_mode: assert property (p_link_mode)
      else $error("link mode bit not taken");

   property p_bank_other;
      (wr_scr && !page_now) |=> $stable(g_link[1].scr_r);
   endproperty
   a_bank_other: assert property (p_bank_other)
      else $error("unpaged link copy changed");

   property p_enter_reset;
      (wr_srst && reg_wdata == SRST_ENTER && page_now)
         |=> link_cfg[1].soft_reset && $stable(link_cfg[0].soft_reset);
   endproperty
   a_enter_reset: assert property (p_enter_reset)
      else $error("paged deframer not held in reset");

   property p_leave_reset;
      (wr_srst && reg_wdata == SRST_LEAVE && !page_now)
         |=> !link_cfg[0].soft_reset;
   endproperty
   a_leave_reset: assert property (p_leave_reset)
      else $error("paged deframer not released");

   property p_descramble;
      (wr_scr && !page_now) |=>
         link_cfg[0].descramble_en == $past(reg_wdata[SCR_BIT]) &&
         link_cfg[0].lanes_m1 == $past(reg_wdata[4:0]);
   endproperty
   a_descramble: assert property (p_descramble)
      else $error("scramble or lane field wrong");

   property p_subclass;
      (wr_sub && page_now) |=>
         link_cfg[1].subclass == $past(reg_wdata[7:5]) &&
         link_cfg[1].sample_m1 == $past(reg_wdata[4:0]);
   endproperty
   a_subclass: assert property (p_subclass)
      else $error("subclass or sample size field wrong");

   property p_chan_page;
      (wr_ghi && !chan_page_r[0]) |=> $stable(chan_cfg[0].gain);
   endproperty
   a_chan_page: assert property (p_chan_page)
      else $error("unpaged channel gain changed");

   property p_gain_lo;
      (wr_glo && chan_page_r[2]) |=>
         chan_cfg[2].gain[7:0] == $past(reg_wdata);
   endproperty
   a_gain_lo: assert property (p_gain_lo)
      else $error("gain low byte not taken");

   property p_osc;
      (wr_osc && chan_page_r[5]) |=>
         chan_cfg[5].osc_en == $past(reg_wdata[OSC_EN_BIT]) &&
         chan_cfg[5].modulus_en == $past(reg_wdata[OSC_MOD_BIT]) &&
         chan_cfg[5].sideband_lower == $past(reg_wdata[OSC_SB_BIT]);
   endproperty
   a_osc: assert property (p_osc)
      else $error("oscillator controls not taken");

   property p_readback;
      (reg_rd && reg_addr == OFS_LINK_CTRL && !reg_wr)
         |=> reg_rdata == $past(link_ctl_r);
   endproperty
   a_readback: assert property (p_readback)
      else $error("link control readback wrong");

   property p_mismatch_clear;
      ##1 (link_dual == serial_link_config_dual) |=> !mode_mismatch;
   endproperty
   a_mismatch_clear: assert property (p_mismatch_clear)
      else $error("mode mismatch flag raised without cause");

   property p_link_page;
      wr_link |=> link_page == $past(reg_wdata[LC_PAGE_BIT]);
   endproperty
   a_link_page: assert property (p_link_page)
      else $error("link page bit not taken");

   property p_link_enable;
      wr_link |=> link_enable == $past(reg_wdata[LC_EN_LSB+1:LC_EN_LSB]);
   endproperty
   a_link_enable: assert property (p_link_enable)
      else $error("link enable field not taken");

   property p_link_hold;
      !wr_link |=> $stable(link_ctl_r);
   endproperty
   a_link_hold: assert property (p_link_hold)
      else $error("link control changed without a write");

   property p_bank_sub;
      (wr_sub && page_now) |=> $stable(g_link[0].sub_r);
   endproperty
   a_bank_sub: assert property (p_bank_sub)
      else $error("unpaged link sample size changed");

   property p_bank_srst;
      (wr_srst && !page_now) |=> $stable(link_cfg[1].soft_reset);
   endproperty
   a_bank_srst: assert property (p_bank_srst)
      else $error("unpaged link reset state changed");

   property p_enter_reset0;
      (wr_srst && reg_wdata == SRST_ENTER && !page_now)
         |=> link_cfg[0].soft_reset;
   endproperty
   a_enter_reset0: assert property (p_enter_reset0)
      else $error("first link deframer not held in reset");

   property p_leave_reset1;
      (wr_srst && reg_wdata == SRST_LEAVE && page_now)
         |=> !link_cfg[1].soft_reset;
   endproperty
   a_leave_reset1: assert property (p_leave_reset1)
      else $error("second link deframer not released");

   property p_srst_other;
      (wr_srst && reg_wdata != SRST_ENTER && reg_wdata != SRST_LEAVE) |=>
         $stable(link_cfg[0].soft_reset) && $stable(link_cfg[1].soft_reset);
   endproperty
   a_srst_other: assert property (p_srst_other)
      else $error("other reset byte changed reset state");

   property p_descramble1;
      (wr_scr && page_now) |=>
         link_cfg[1].descramble_en == $past(reg_wdata[SCR_BIT]) &&
         link_cfg[1].lanes_m1 == $past(reg_wdata[LANES_LSB+4:LANES_LSB]);
   endproperty
   a_descramble1: assert property (p_descramble1)
      else $error("second link scramble or lane field wrong");

   property p_subclass0;
      (wr_sub && !page_now) |=>
         link_cfg[0].subclass == $past(reg_wdata[SUBCL_LSB+2:SUBCL_LSB]) &&
         link_cfg[0].sample_m1 == $past(reg_wdata[NP_LSB+4:NP_LSB]);
   endproperty
   a_subclass0: assert property (p_subclass0)
      else $error("first link subclass or sample size wrong");

   property p_chan_page_set;
      wr_chp |=> chan_page_r == ($past(reg_wdata) & CHP_MASK);
   endproperty
   a_chan_page_set: assert property (p_chan_page_set)
      else $error("channel page not taken");

   property p_gain_hi;
      (wr_ghi && chan_page_r[3]) |=>
         chan_cfg[3].gain[GAIN_W-1:DATA_W] ==
            $past(reg_wdata[GAIN_W-DATA_W-1:0]);
   endproperty
   a_gain_hi: assert property (p_gain_hi)
      else $error("gain high bits not taken");

   property p_gain_split;
      (wr_glo && chan_page_r[1]) |=>
         $stable(chan_cfg[1].gain[GAIN_W-1:DATA_W]);
   endproperty
   a_gain_split: assert property (p_gain_split)
      else $error("gain low write touched the high bits");

   property p_gain_unpaged;
      (wr_glo && !chan_page_r[5]) |=> $stable(chan_cfg[5].gain);
   endproperty
   a_gain_unpaged: assert property (p_gain_unpaged)
      else $error("unpaged channel gain changed");

   property p_osc_unpaged;
      (wr_osc && !chan_page_r[4]) |=> $stable(g_chan[4].osc_r);
   endproperty
   a_osc_unpaged: assert property (p_osc_unpaged)
      else $error("unpaged channel oscillator changed");

   property p_osc_en;
      (wr_osc && chan_page_r[1]) |=>
         chan_cfg[1].osc_en == $past(reg_wdata[OSC_EN_BIT]) &&
         chan_cfg[1].modulus_en == $past(reg_wdata[OSC_MOD_BIT]);
   endproperty
   a_osc_en: assert property (p_osc_en)
      else $error("oscillator enable or modulus not taken");

   property p_sideband;
      (wr_osc && chan_page_r[0]) |=>
         chan_cfg[0].sideband_lower == $past(reg_wdata[OSC_SB_BIT]);
   endproperty
   a_sideband: assert property (p_sideband)
      else $error("sideband select not taken");
endmodule : dfc_setup_regs

// File: testbench/dfc_host_model.sv
// host controller model that programs the setup bank over the register port
`timescale 1ns/100ps
module dfc_host_model (
   input wire logic clk,
   input wire logic [dfc_pkg::DATA_W-1:0] reg_rdata,
   output logic [dfc_pkg::ADDR_W-1:0] reg_addr,
   output logic [dfc_pkg::DATA_W-1:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   import dfc_pkg::*;
   initial begin
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // strobe lowered at the taking edge; the next access waits one more edge
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a,
         output logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
   // links stay disabled; the paged deframer is parked in reset meanwhile
   task automatic link_setup(input logic dual, input logic page,
         input logic [DATA_W-1:0] scr_l, input logic [DATA_W-1:0] sub_np);
      wr(OFS_LINK_CTRL, {4'h0, dual, page, 2'b00});
      wr(OFS_SOFT_RST, SRST_ENTER);
      wr(OFS_SCR_LANES, scr_l);
      wr(OFS_SUB_NP, sub_np);
      wr(OFS_SOFT_RST, SRST_LEAVE);
   endtask : link_setup
   task automatic links_setup(input logic dual,
         input logic [DATA_W-1:0] s0, input logic [DATA_W-1:0] n0,
         input logic [DATA_W-1:0] s1, input logic [DATA_W-1:0] n1);
      link_setup(dual, 1'b0, s0, n0);
      if (dual) begin
         link_setup(dual, 1'b1, s1, n1);
      end
   endtask : links_setup
   task automatic chan_setup(input logic bypass, input logic [7:0] page,
         input logic [11:0] g, input logic [7:0] osc);
      if (!bypass) begin
         wr(OFS_CHAN_PAGE, page);
         wr(OFS_GAIN_LO, g[7:0]);
         wr(OFS_GAIN_HI, {4'h0, g[11:8]});
         wr(OFS_OSC_CTRL, osc);
      end
   endtask : chan_setup
endmodule : dfc_host_model

// File: testbench/dfc_setup_regs_tb.sv
// self-checking bench for the deframer and channel setup bank
`timescale 1ns/100ps
module dfc_setup_regs_tb;
   import dfc_pkg::*;
   logic clk, rst, mode_dual_in, reg_wr, reg_rd;
   logic link_dual, link_page, mode_mismatch;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, pg, od;
   logic [1:0] link_enable;
   wire logic [4:0] link_st = {mode_mismatch, link_dual, link_page, link_enable};
   dfc_link_cfg_t [NUM_LINKS-1:0] link_cfg;
   dfc_chan_cfg_t [NUM_CHAN-1:0] chan_cfg;
   logic [DATA_W-1:0] sl [2];
   logic [DATA_W-1:0] sn [2];
   logic [GAIN_W-1:0] eg [NUM_CHAN];
   logic [3:0] eo [NUM_CHAN];
   logic [GAIN_W-1:0] g;
   int num_errors = 0;
   int total_checks = 0;
   int lo;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   dfc_setup_regs i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .serial_link_config_dual(mode_dual_in),
      .link_dual(link_dual), .link_page(link_page),
      .link_enable(link_enable), .mode_mismatch(mode_mismatch),
      .link_cfg(link_cfg), .chan_cfg(chan_cfg));
   dfc_host_model i_host (.clk(clk), .reg_rdata(reg_rdata),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd));
   function automatic logic [14:0] exp_link(input int l);
      return {1'b0, sl[l][SCR_BIT], sl[l][4:0], sn[l]};
   endfunction : exp_link
   function automatic logic [3:0] exp_osc(input logic [7:0] d);
      return {d[OSC_EN_BIT], d[OSC_MOD_BIT], d[OSC_SB_BIT], d[OSC_TONE_BIT]};
   endfunction : exp_osc
   // lets the late mismatch flag land before outputs are looked at
   task automatic settle;
      @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: output %h not %h", $time, got, exp);
      end
   endtask : chk_out
   task automatic chk_reg(input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] d;
      i_host.rd(a, d);
      total_checks++;
      if (d !== exp) begin
         num_errors++;
         $display("wrong value at %0t: read %h gave %h not %h", $time, a, d,
            exp);
      end
   endtask : chk_reg
   task automatic check_links;
      settle;
      for (int l = 0; l < NUM_LINKS; l++) begin
         chk_out(link_cfg[l], exp_link(l));
      end
   endtask : check_links
   task automatic check_chans;
      settle;
      for (int i = 0; i < NUM_CHAN; i++) begin
         chk_out(chan_cfg[i], {eg[i], eo[i]});
      end
   endtask : check_chans
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      report_and_stop;
   end
   initial begin
      rst = 1'b1;
      mode_dual_in = 1'b0;
      sl = '{8'h00, 8'h00};
      sn = '{8'h00, 8'h00};
      for (int i = 0; i < NUM_CHAN; i++) begin
         eg[i] = GAIN_UNITY;
         eo[i] = 4'h0;
      end
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      void'($urandom(8));
      check_links();
      check_chans();
      chk_reg(OFS_LINK_CTRL, 8'h00);
      chk_reg(OFS_GAIN_LO, 8'h00);
      // single link leaves the second deframer at reset values
      sl[0] = 8'($urandom) & SCR_MASK;
      sn[0] = 8'($urandom);
      i_host.links_setup(1'b0, sl[0], sn[0], 8'hFF, 8'hFF);
      check_links();
      chk_out(link_st, 5'h00);
      // dual link while the datapath mode still says single
      sl[1] = 8'($urandom) & SCR_MASK;
      sn[1] = 8'($urandom);
      i_host.links_setup(1'b1, sl[0], sn[0], sl[1], sn[1]);
      check_links();
      chk_out(link_st, 5'h1C);
      @(posedge clk);
      mode_dual_in <= 1'b1;
      settle;
      chk_out(mode_mismatch, 1'b0);
      chk_reg(OFS_SCR_LANES, sl[1]);
      i_host.wr(OFS_LINK_CTRL, 8'h08);
      chk_reg(OFS_SUB_NP, sn[0]);
      i_host.wr(OFS_SOFT_RST, SRST_ENTER);
      settle;
      chk_out({link_cfg[1].soft_reset, link_cfg[0].soft_reset}, 2'b01);
      i_host.wr(OFS_SOFT_RST, 8'h05);
      chk_reg(OFS_SOFT_RST, 8'h05);
      chk_out(link_cfg[0].soft_reset, 1'b1);
      i_host.wr(OFS_SOFT_RST, SRST_LEAVE);
      check_links();
      // setup finished: links may be enabled now, reserved bits read zero
      i_host.wr(OFS_LINK_CTRL, 8'hFB);
      chk_reg(OFS_LINK_CTRL, 8'h0B);
      chk_out(link_st, 5'h0B);
      // unmapped place: write ignored, read returns zero
      i_host.wr(12'h131, 8'hFF);
      chk_reg(12'h131, 8'h00);
      i_host.chan_setup(1'b1, 8'h3F, 12'h123, 8'h47);
      check_chans();
      // all channels, none, then random pages
      for (int n = 0; n < 12; n++) begin
         pg = (n == 0) ? 8'hFF : (n == 1) ? 8'h00 : 8'($urandom);
         g = 12'($urandom);
         od = 8'($urandom);
         i_host.chan_setup(1'b0, pg, g, od);
         lo = -1;
         for (int i = NUM_CHAN - 1; i >= 0; i--) begin
            if (pg[i]) begin
               eg[i] = g;
               eo[i] = exp_osc(od);
               lo = i;
            end
         end
         check_chans();
         chk_reg(OFS_CHAN_PAGE, pg & CHP_MASK);
         chk_reg(OFS_GAIN_LO, (lo < 0) ? 8'h00 : g[7:0]);
         chk_reg(OFS_GAIN_HI, (lo < 0) ? 8'h00 : {4'h0, g[11:8]});
         chk_reg(OFS_OSC_CTRL, (lo < 0) ? 8'h00 : (od & OSC_MASK));
      end
      report_and_stop;
   end
endmodule : dfc_setup_regs_tb
